// ### hw/fbas_pkg.sv
// Purpose: Shared constants and types for the flash block access and security block
// Assumes: Byte-wide command space, one byte per host access
// Notes: Flash is modelled as 20 blocks of 32 bytes
package fbas_pkg;

   // ************************************************
   // Command space addresses
   // ************************************************
   localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
   localparam logic [7:0] ADDR_CTRL_HI = 8'h01;
   localparam logic [7:0] ADDR_CLASS = 8'h3e;
   localparam logic [7:0] ADDR_BLOCK = 8'h3f;
   localparam logic [7:0] ADDR_WIN_BASE = 8'h40;
   localparam logic [7:0] ADDR_WIN_LAST = 8'h5f;
   localparam logic [7:0] ADDR_CKSUM = 8'h60;
   localparam logic [7:0] ADDR_ACC_CTRL = 8'h61;

   // ************************************************
   // Block and flash layout
   // ************************************************
   localparam int BLOCK_BYTES = 32;
   localparam int FLASH_BLOCKS = 20;
   localparam int FLASH_BYTES = FLASH_BLOCKS * BLOCK_BYTES;
   localparam logic [5:0] BURST_MAX = 6'h20;
   localparam logic [4:0] XFER_LAST = 5'h1f;
   localparam logic [7:0] ACC_GENERAL = 8'h00;
   localparam logic [7:0] MFG_SUBCLASS = 8'h3a;
   localparam logic [7:0] MFG_SEL_A = 8'h01;
   localparam logic [7:0] MFG_SEL_C = 8'h03;
   localparam logic [7:0] MFG_BLOCKS = 8'h03;
   localparam logic [4:0] MFG_BASE_BLK = 5'h10;
   localparam logic [7:0] KEY_CLASS = 8'h70;
   localparam logic [4:0] KEY_BLK = 5'h13;
   localparam logic [4:0] KEY_UNSEAL_OFS = 5'h00;
   localparam logic [4:0] KEY_FULL_OFS = 5'h04;
   localparam logic [7:0] CKSUM_BASE = 8'hff;

   // ************************************************
   // Control word codes and status bits
   // ************************************************
   localparam logic [15:0] SUB_SEAL = 16'h0020;
   localparam int SS_BIT = 13;
   localparam int RIGHTS_BIT = 14;
   localparam int STAT_HI_LSB = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_COMMIT = 3'b100
   } fbas_state_t;

   typedef enum logic [2:0] {
      MODE_FULL = 3'b001,
      MODE_UNLOCKED_MODE = 3'b010,
      MODE_SEALED = 3'b100
   } fbas_mode_t;

   typedef enum logic [2:0] {
      PEND_NONE = 3'b001,
      PEND_UNSEAL = 3'b010,
      PEND_FULL = 3'b100
   } fbas_pend_t;

   localparam fbas_mode_t MODE_AT_RESET = MODE_FULL;

   typedef struct packed {
      fbas_state_t state;
      fbas_mode_t mode;
      fbas_pend_t pend;
      logic [31:0][7:0] win;
      logic [7:0] class_sel;
      logic [7:0] blk_sel;
      logic [7:0] acc_ctrl;
      logic [7:0] cksum;
      logic [7:0] ctrl_lo;
      logic win_valid;
      logic [4:0] win_blk;
      logic [4:0] cnt;
      logic [5:0] burst;
      logic ovf;
      logic [7:0] rdata;
      logic busy;
      logic ss;
      logic rights;
   } fbas_regs_t;

endpackage : fbas_pkg

// ### hw/fbas_top.sv
// Purpose: Block window, checksum commit and security modes for the data flash
// Assumes: Host accesses are single-cycle strobes synchronous to clock
// Notes: Flash array has no reset so its contents survive rstn
`timescale 1ns/1ps

// What this block does
// - Access control value 0x00 at 0x61 selects general flash block access.
// - Window shows the 32 bytes of the selected block, readable and writable.
// - Each window byte is read or written on its own address.
// - Window goes to flash only after a correct checksum write at 0x60.
// - Block select picks the 32-byte block; address is 0x40 plus offset mod 32.
// - Over 32 window bytes in one write is discarded.
// - Any written value is accepted without range checking.
// - Committed flash survives power cycles and reset.
// - Three 32-byte manufacturer blocks give 96 bytes of storage.
// - Unlocked with access control 0x00, class 58 reaches the manufacturer blocks.
// - Sealed or control nonzero: block select 1,2,3 load blocks A,B,C.
// - A good checksum writes the window back to that manufacturer block, except block A while sealed.
// - Full, unlocked and sealed modes; sealed allows A read, B/C read-write.
// - Class select is rejected while sealed.
// - Key writes are allowed only in full access mode.
// - Two back-to-back key words per transition; other control write aborts.
// - Sealed bit is set while sealed, cleared on correct unseal keys.
// - Full rights state bit clears on correct full-access keys.
// - Keys live in flash and are updatable only in full access.
module fbas_top (
   input wire logic clock,
   input wire logic rstn,
   input wire logic cmd_start,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] cmd_rdata,
   output logic busy,
   output logic window_valid,
   output logic sealed_status_bit,
   output logic full_rights_state_bit
);

   fbas_pkg::fbas_regs_t r_reg;
   fbas_pkg::fbas_regs_t r_next;

   // Nonvolatile store, deliberately outside the reset domain
   logic [7:0] flash_mem [0:fbas_pkg::FLASH_BYTES-1];

   // ************************************************
   // Helpers
   // ************************************************
   function automatic logic [15:0] key_word(input logic [4:0] ofs);
      logic [9:0] a;
      a = {fbas_pkg::KEY_BLK, ofs};
      // Entry order matches readback; the low byte sits at the lower offset
      return {flash_mem[a + 10'h001], flash_mem[a]};
   endfunction : key_word

   function automatic logic [5:0] pick_block(
      input logic [7:0] cls,
      input logic [7:0] blk,
      input logic [7:0] acc,
      input fbas_pkg::fbas_mode_t md
   );
      logic [7:0] rel;
      rel = blk - fbas_pkg::MFG_SEL_A;
      if (md == fbas_pkg::MODE_SEALED || acc != fbas_pkg::ACC_GENERAL) begin
         if (blk >= fbas_pkg::MFG_SEL_A && blk <= fbas_pkg::MFG_SEL_C) begin
            return {1'b1, fbas_pkg::MFG_BASE_BLK + rel[4:0]};
         end
         return 6'h00;
      end
      if (cls == fbas_pkg::MFG_SUBCLASS) begin
         if (blk < fbas_pkg::MFG_BLOCKS) begin
            return {1'b1, fbas_pkg::MFG_BASE_BLK + blk[4:0]};
         end
         return 6'h00;
      end
      // Key block is reached only through its own class, block 0
      if (cls == fbas_pkg::KEY_CLASS) begin
         return {(blk == 8'h00), fbas_pkg::KEY_BLK};
      end
      // General classes fold onto 16 blocks; block select picks the 32-byte half
      return {1'b1, 1'b0, cls[2:0], blk[0]};
   endfunction : pick_block

   // ************************************************
   // Next-state logic
   // ************************************************
   always_comb begin
      logic [7:0] sum;
      logic [5:0] pick;
      logic [15:0] word;
      logic [4:0] idx;
      logic in_win;
      logic sealed;
      logic commit_ok;
      logic reselect;
      logic [5:0] burst_now;
      sum = 8'h00;
      pick = 6'h00;
      word = {cmd_wdata, r_reg.ctrl_lo};
      idx = cmd_addr[4:0];
      in_win = cmd_addr >= fbas_pkg::ADDR_WIN_BASE && cmd_addr <= fbas_pkg::ADDR_WIN_LAST;
      sealed = r_reg.mode == fbas_pkg::MODE_SEALED;
      commit_ok = 1'b0;
      reselect = 1'b0;
      // A start in the same cycle as a write opens a fresh transaction
      burst_now = cmd_start ? 6'h00 : r_reg.burst;
      r_next = r_reg;

      for (int i = 0; i < fbas_pkg::BLOCK_BYTES; i++) begin
         sum = sum + r_reg.win[i];
      end

      if (cmd_start) begin
         r_next.burst = 6'h00;
      end

      // Flash transfer engine
      case (r_reg.state)
         fbas_pkg::ST_LOAD: begin
            r_next.win[r_reg.cnt] = flash_mem[{r_reg.win_blk, r_reg.cnt}];
            r_next.cnt = r_reg.cnt + 5'h01;
            // Window is not valid until the last byte lands
            if (r_reg.cnt == fbas_pkg::XFER_LAST) begin
               r_next.state = fbas_pkg::ST_IDLE;
               r_next.busy = 1'b0;
               r_next.win_valid = 1'b1;
            end
         end
         fbas_pkg::ST_COMMIT: begin
            // Flash bytes themselves are written by the array process
            r_next.cnt = r_reg.cnt + 5'h01;
            if (r_reg.cnt == fbas_pkg::XFER_LAST) begin
               r_next.state = fbas_pkg::ST_IDLE;
               r_next.busy = 1'b0;
            end
         end
         default: begin
         end
      endcase

      // ************************************************
      // Read path
      // ************************************************
      if (cmd_rd) begin
         if (cmd_addr == fbas_pkg::ADDR_CTRL_LO) begin
            r_next.rdata = 8'h00;
         end else if (cmd_addr == fbas_pkg::ADDR_CTRL_HI) begin
            r_next.rdata = 8'h00;
            r_next.rdata[fbas_pkg::SS_BIT - fbas_pkg::STAT_HI_LSB] = r_reg.ss;
            r_next.rdata[fbas_pkg::RIGHTS_BIT - fbas_pkg::STAT_HI_LSB] = r_reg.rights;
         end else if (cmd_addr == fbas_pkg::ADDR_CLASS) begin
            // Protected registers read as zero while sealed
            r_next.rdata = sealed ? 8'h00 : r_reg.class_sel;
         end else if (cmd_addr == fbas_pkg::ADDR_BLOCK) begin
            r_next.rdata = r_reg.blk_sel;
         end else if (in_win) begin
            r_next.rdata = r_reg.win_valid ? r_reg.win[idx] : 8'h00;
         end else if (cmd_addr == fbas_pkg::ADDR_CKSUM) begin
            r_next.rdata = r_reg.cksum;
         end else if (cmd_addr == fbas_pkg::ADDR_ACC_CTRL) begin
            r_next.rdata = sealed ? 8'h00 : r_reg.acc_ctrl;
         end else begin
            r_next.rdata = 8'h00;
         end
      end

      // ************************************************
      // Write path
      // ************************************************
      if (cmd_wr) begin
         if (cmd_addr == fbas_pkg::ADDR_CTRL_LO) begin
            // Low byte waits for its high byte; only the high byte acts
            r_next.ctrl_lo = cmd_wdata;
         end else if (cmd_addr == fbas_pkg::ADDR_CTRL_HI) begin
            // Complete control word; a non-key word drops any pending first key
            r_next.pend = fbas_pkg::PEND_NONE;
            if (word == fbas_pkg::SUB_SEAL) begin
               r_next.mode = fbas_pkg::MODE_SEALED;
               r_next.ss = 1'b1;
               r_next.rights = 1'b1;
               // A window opened before sealing must not stay editable
               r_next.win_valid = 1'b0;
            end else if (r_reg.pend == fbas_pkg::PEND_UNSEAL &&
                         word == key_word(fbas_pkg::KEY_UNSEAL_OFS + 5'h02)) begin
               r_next.mode = fbas_pkg::MODE_UNLOCKED_MODE;
               r_next.ss = 1'b0;
            end else if (r_reg.pend == fbas_pkg::PEND_FULL &&
                         word == key_word(fbas_pkg::KEY_FULL_OFS + 5'h02)) begin
               r_next.mode = fbas_pkg::MODE_FULL;
               r_next.rights = 1'b0;
            end else if (sealed && word == key_word(fbas_pkg::KEY_UNSEAL_OFS)) begin
               r_next.pend = fbas_pkg::PEND_UNSEAL;
            end else if (r_reg.mode == fbas_pkg::MODE_UNLOCKED_MODE &&
                         word == key_word(fbas_pkg::KEY_FULL_OFS)) begin
               r_next.pend = fbas_pkg::PEND_FULL;
            end
         end else if (r_reg.state != fbas_pkg::ST_IDLE) begin
            // Flash transfer in progress: other writes are dropped
            r_next.ovf = r_reg.ovf;
         end else if (cmd_addr == fbas_pkg::ADDR_CLASS) begin
            if (!sealed) begin
               r_next.class_sel = cmd_wdata;
               reselect = 1'b1;
            end
         end else if (cmd_addr == fbas_pkg::ADDR_BLOCK) begin
            r_next.blk_sel = cmd_wdata;
            reselect = 1'b1;
         end else if (cmd_addr == fbas_pkg::ADDR_ACC_CTRL) begin
            if (!sealed) begin
               r_next.acc_ctrl = cmd_wdata;
               reselect = 1'b1;
            end
         end else if (in_win) begin
            if (burst_now >= fbas_pkg::BURST_MAX) begin
               r_next.ovf = 1'b1;
            end else begin
               r_next.burst = burst_now + 6'h01;
               // No range check on the value itself
               if (r_reg.win_valid && !(sealed && r_reg.win_blk == fbas_pkg::MFG_BASE_BLK)) begin
                  r_next.win[idx] = cmd_wdata;
               end
            end
         end else if (cmd_addr == fbas_pkg::ADDR_CKSUM) begin
            r_next.cksum = cmd_wdata;
            commit_ok = r_reg.win_valid && !r_reg.ovf &&
                        (fbas_pkg::CKSUM_BASE - sum) == cmd_wdata;
            if (sealed && r_reg.win_blk == fbas_pkg::MFG_BASE_BLK) begin
               commit_ok = 1'b0;
            end
            // Sealed commits may only reach the manufacturer blocks
            if (sealed && (r_reg.win_blk < fbas_pkg::MFG_BASE_BLK ||
                           r_reg.win_blk >= fbas_pkg::KEY_BLK)) begin
               commit_ok = 1'b0;
            end
            if (r_reg.win_blk == fbas_pkg::KEY_BLK && r_reg.mode != fbas_pkg::MODE_FULL) begin
               commit_ok = 1'b0;
            end
            if (commit_ok) begin
               r_next.state = fbas_pkg::ST_COMMIT;
               r_next.cnt = 5'h00;
               r_next.busy = 1'b1;
            end
         end
      end

      // ************************************************
      // Block selection
      // ************************************************
      // Reselection restarts the window, so a stale overflow cannot block it
      if (reselect) begin
         pick = pick_block(r_next.class_sel, r_next.blk_sel, r_next.acc_ctrl, r_reg.mode);
         r_next.win_valid = 1'b0;
         r_next.ovf = 1'b0;
         if (pick[5]) begin
            r_next.win_blk = pick[4:0];
            r_next.state = fbas_pkg::ST_LOAD;
            r_next.cnt = 5'h00;
            r_next.busy = 1'b1;
         end
      end
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.state <= fbas_pkg::ST_IDLE;
         r_reg.mode <= fbas_pkg::MODE_AT_RESET;
         r_reg.pend <= fbas_pkg::PEND_NONE;
         r_reg.ss <= 1'b0;
         r_reg.rights <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ************************************************
   // Flash array
   // ************************************************
   // Flash writes one byte per cycle while committing
   always_ff @(posedge clock) begin
      if (r_reg.state == fbas_pkg::ST_COMMIT) begin
         flash_mem[{r_reg.win_blk, r_reg.cnt}] <= r_reg.win[r_reg.cnt];
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign cmd_rdata = r_reg.rdata;
   assign busy = r_reg.busy;
   assign window_valid = r_reg.win_valid;
   assign sealed_status_bit = r_reg.ss;
   assign full_rights_state_bit = r_reg.rights;

endmodule : fbas_top

// ### verification/fbas_top_asserts.sv
// Purpose: Port-level checks of the flash block access and security block
// Assumes: One clock domain, rstn asynchronous and active low
// Notes: Bound to every fbas_top instance
`timescale 1ns/1ps
module fbas_top_asserts (
   input wire logic clock,
   input wire logic rstn,
   input wire logic cmd_start,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] cmd_rdata,
   input wire logic busy,
   input wire logic window_valid,
   input wire logic sealed_status_bit,
   input wire logic full_rights_state_bit
);
   logic [5:0] busy_cnt;
   logic ctrl_hi_wr;
   assign ctrl_hi_wr = cmd_wr && cmd_addr == 8'h01;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_cnt <= 6'h00;
      end else begin
         busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Bench spaces strobes one idle cycle apart
   sequence seal_word;
      cmd_wr && cmd_addr == 8'h00 && cmd_wdata == 8'h20 ##1 !cmd_wr
      ##1 cmd_wr && cmd_addr == 8'h01 && cmd_wdata == 8'h00;
   endsequence
   sequence load_done;
      busy && !window_valid ##32 !busy && window_valid;
   endsequence
   chk_seal_sets: assert property (seal_word |=> sealed_status_bit && full_rights_state_bit)
      else $error("seal word did not seal");
   chk_seal_drops_window: assert property (seal_word |=> !window_valid)
      else $error("window still valid after sealing");
   chk_busy_len: assert property ($fell(busy) |-> busy_cnt == 6'h20)
      else $error("busy not 32 cycles");
   chk_sealed_load: assert property (sealed_status_bit && !busy && cmd_wr && cmd_addr == 8'h3f
      && cmd_wdata inside {[8'h01:8'h03]} |=> load_done)
      else $error("sealed select did not load");
   chk_sealed_ignore: assert property (sealed_status_bit && !busy && cmd_wr
      && cmd_addr inside {8'h3e, 8'h61} |=> !busy)
      else $error("sealed class write acted");
   chk_class_zero: assert property (sealed_status_bit && cmd_rd && cmd_addr == 8'h3e
      |=> cmd_rdata == 8'h00)
      else $error("class read not zero");
   chk_status_rd: assert property (cmd_rd && cmd_addr == 8'h01 |=> cmd_rdata[6:5] ==
      {$past(full_rights_state_bit), $past(sealed_status_bit)})
      else $error("status byte wrong");
   chk_rdata_hold: assert property (!cmd_rd |=> $stable(cmd_rdata))
      else $error("read data moved");
   chk_mode_cause: assert property ($changed(sealed_status_bit) || $changed(full_rights_state_bit)
      |-> $past(ctrl_hi_wr))
      else $error("mode changed without control word");
   chk_sealed_fas: assert property (sealed_status_bit |-> full_rights_state_bit)
      else $error("sealed but full rights");
endmodule : fbas_top_asserts
bind fbas_top fbas_top_asserts u_fbas_top_asserts (.clock(clock), .rstn(rstn),
   .cmd_start(cmd_start), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
   .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .busy(busy), .window_valid(window_valid),
   .sealed_status_bit(sealed_status_bit), .full_rights_state_bit(full_rights_state_bit));

// ### verification/fbas_host.sv
// Purpose: Host model driving the command space
// Assumes: Inputs change at the falling edge, one byte per strobe
// Notes: Strobes are spaced one idle cycle apart
`timescale 1ns/1ps
module fbas_host (
   input wire logic clock,
   input wire logic busy,
   input wire logic [7:0] cmd_rdata,
   output logic cmd_start,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_addr,
   output logic [7:0] cmd_wdata
);
   initial begin
      cmd_start = 1'b0;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_addr = 8'h00;
      cmd_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      cmd_addr = a;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      @(negedge clock);
      cmd_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      cmd_addr = a;
      cmd_rd = 1'b1;
      @(negedge clock);
      cmd_rd = 1'b0;
      d = cmd_rdata;
   endtask : rd
   task automatic idle();
      for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
         @(negedge clock);
      end
   endtask : idle
   task automatic ctrl(input logic [15:0] w);
      wr(fbas_pkg::ADDR_CTRL_LO, w[7:0]);
      wr(fbas_pkg::ADDR_CTRL_HI, w[15:8]);
   endtask : ctrl
   // Any of these writes may start a load, so wait each out
   task automatic sel(input logic [7:0] cls, input logic [7:0] blk);
      wr(fbas_pkg::ADDR_CLASS, cls);
      idle();
      wr(fbas_pkg::ADDR_ACC_CTRL, fbas_pkg::ACC_GENERAL);
      idle();
      wr(fbas_pkg::ADDR_BLOCK, blk);
      idle();
   endtask : sel
   function automatic logic [7:0] ck(input logic [31:0][7:0] d);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 32; i++) begin
         s = s + d[i];
      end
      return 8'hff - s;
   endfunction : ck
   // Opens a write transaction so the window byte count restarts
   task automatic start();
      @(negedge clock);
      cmd_start = 1'b1;
      @(negedge clock);
      cmd_start = 1'b0;
   endtask : start
   task automatic commit(input logic [31:0][7:0] d, input int n);
      start();
      for (int i = 0; i < n; i++) begin
         wr(8'h40 + 8'(i % 32), d[i % 32]);
      end
      wr(fbas_pkg::ADDR_CKSUM, ck(d));
   endtask : commit
endmodule : fbas_host

// ### verification/test_flash_block_access_security.sv
// Purpose: Self-checking run of block access, commit and security modes
// Assumes: 50 MHz clock, inputs driven at the falling edge
// Notes: Keys are written first since flash powers up unknown
`timescale 1ns/1ps
module test_flash_block_access_security;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic cmd_start, cmd_wr, cmd_rd, busy, window_valid, ss, rights;
   logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, r;
   logic [31:0][7:0] blk_a, blk_b, keyb;
   int miscompares = 0;
   int num_checks = 0;
   always #10 clock = ~clock;
   fbas_top u_fbas_top (.clock(clock), .rstn(rstn), .cmd_start(cmd_start), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
      .busy(busy), .window_valid(window_valid), .sealed_status_bit(ss),
      .full_rights_state_bit(rights));
   fbas_host u_fbas_host (.clock(clock), .busy(busy), .cmd_rdata(cmd_rdata),
      .cmd_start(cmd_start), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] stat_byte(input logic s, input logic f);
      return {1'b0, f, s, 5'h00};
   endfunction : stat_byte
   task automatic stat(input logic s, input logic f);
      u_fbas_host.rd(fbas_pkg::ADDR_CTRL_HI, r);
      check(r & 8'h60, stat_byte(s, f));
      check({1'b0, rights, ss, 5'h00}, stat_byte(s, f));
   endtask : stat
   task automatic rdblk(input logic [31:0][7:0] d);
      for (int i = 0; i < 32; i++) begin
         u_fbas_host.rd(8'h40 + 8'(i), r);
         check(r, d[i]);
      end
   endtask : rdblk
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   // Whole run is a few thousand cycles
   initial begin
      #(20 * 20000);
      miscompares++;
      final_report();
   end
   initial begin
      void'($urandom(4528));
      for (int i = 0; i < 32; i++) begin
         blk_a[i] = 8'($urandom);
         blk_b[i] = 8'($urandom);
         keyb[i] = 8'($urandom) | ((i % 2) ? 8'h80 : 8'h00);
      end
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      stat(1'b0, 1'b0);
      u_fbas_host.sel(fbas_pkg::KEY_CLASS, 8'h00);
      u_fbas_host.commit(keyb, 32);
      u_fbas_host.idle();
      u_fbas_host.sel(fbas_pkg::MFG_SUBCLASS, 8'h00);
      u_fbas_host.commit(blk_a, 32);
      u_fbas_host.idle();
      u_fbas_host.sel(fbas_pkg::MFG_SUBCLASS, 8'h01);
      u_fbas_host.commit(blk_b, 32);
      check({7'h00, busy}, 8'h01);
      u_fbas_host.idle();
      u_fbas_host.sel(fbas_pkg::MFG_SUBCLASS, 8'h01);
      rdblk(blk_b);
      u_fbas_host.start();
      u_fbas_host.wr(8'h45, ~blk_b[5]);
      u_fbas_host.wr(fbas_pkg::ADDR_CKSUM, u_fbas_host.ck(blk_b));
      check({7'h00, busy}, 8'h00);
      u_fbas_host.commit(blk_a, 33);
      check({7'h00, busy}, 8'h00);
      u_fbas_host.sel(fbas_pkg::MFG_SUBCLASS, 8'h01);
      rdblk(blk_b);
      $display("test general done");
      u_fbas_host.ctrl(fbas_pkg::SUB_SEAL);
      stat(1'b1, 1'b1);
      check({7'h00, window_valid}, 8'h00);
      u_fbas_host.rd(8'h40, r);
      check(r, 8'h00);
      u_fbas_host.wr(fbas_pkg::ADDR_CLASS, 8'h50);
      u_fbas_host.rd(fbas_pkg::ADDR_CLASS, r);
      check(r, 8'h00);
      u_fbas_host.wr(fbas_pkg::ADDR_BLOCK, 8'h01);
      u_fbas_host.idle();
      u_fbas_host.start();
      u_fbas_host.wr(8'h40, ~blk_a[0]);
      rdblk(blk_a);
      u_fbas_host.wr(fbas_pkg::ADDR_CKSUM, u_fbas_host.ck(blk_a));
      check({7'h00, busy}, 8'h00);
      blk_b[7] = ~blk_b[7];
      u_fbas_host.wr(fbas_pkg::ADDR_BLOCK, 8'h02);
      u_fbas_host.idle();
      u_fbas_host.commit(blk_b, 32);
      check({7'h00, busy}, 8'h01);
      u_fbas_host.idle();
      u_fbas_host.wr(fbas_pkg::ADDR_BLOCK, 8'h02);
      u_fbas_host.idle();
      rdblk(blk_b);
      $display("test sealed done");
      u_fbas_host.ctrl({keyb[1], keyb[0]});
      u_fbas_host.ctrl(16'h0000);
      u_fbas_host.ctrl({keyb[3], keyb[2]});
      stat(1'b1, 1'b1);
      u_fbas_host.ctrl({keyb[1], keyb[0]});
      u_fbas_host.ctrl({keyb[3], keyb[2]});
      stat(1'b0, 1'b1);
      u_fbas_host.sel(fbas_pkg::KEY_CLASS, 8'h00);
      u_fbas_host.commit(keyb, 32);
      check({7'h00, busy}, 8'h00);
      u_fbas_host.ctrl({keyb[5], keyb[4]});
      u_fbas_host.ctrl({keyb[7], keyb[6]});
      stat(1'b0, 1'b0);
      $display("test keys done");
      u_fbas_host.wr(fbas_pkg::ADDR_ACC_CTRL, 8'h01);
      u_fbas_host.idle();
      check({7'h00, window_valid}, 8'h00);
      u_fbas_host.wr(fbas_pkg::ADDR_BLOCK, 8'h02);
      u_fbas_host.idle();
      check({7'h00, window_valid}, 8'h01);
      rdblk(blk_b);
      u_fbas_host.sel(8'h50, 8'h01);
      u_fbas_host.commit(blk_a, 32);
      check({7'h00, busy}, 8'h01);
      u_fbas_host.idle();
      u_fbas_host.sel(8'h50, 8'h01);
      check({7'h00, window_valid}, 8'h01);
      rdblk(blk_a);
      $display("test access control done");
      rstn = 1'b0;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      stat(1'b0, 1'b0);
      u_fbas_host.sel(fbas_pkg::MFG_SUBCLASS, 8'h01);
      rdblk(blk_b);
      $display("test reset done");
      final_report();
   end
endmodule : test_flash_block_access_security
